// file: hdl/isec_top.sv
// What this block does
// - Six sticky event flags, write one clears
// - Mask bit 5 gates link change interrupt
// - Mask bit 4 gates transmit underrun interrupt
// - Mask bit 3 gates overflow counter interrupt
// - Mask bit 2 gates receive overflow interrupt
// - Mask bit 1 gates packet sent interrupt
// - Mask bit 0 gates packet received interrupt
// - Mask bit 7 enables buffer pointer wrap
// - Setting wrap enable loads read high 0Ch
// - Station address from image words 0-2
// - Ctrl 1:0 = 01 loads vendor/product ids
// - Ctrl 3:2 = 01 accepts pin control word
// - Word 7 bits 3:0 only 8-bit, ctrl 7:6
// - Word 7 bits 7,8,15:12 gated by ctrl, 15 and 13:12 wide bus only
// - Word 6 bits 0-2 set strobe polarity
// - Word 6 bits 3-4 set interrupt polarity/drive
// - Word 7 bits 0-1 set wake polarity/pulse
// - Word 7 bits 2-3 enable wake events
// - Word 7 bit 8 phy, bit 7 LED
// - Word 7 13:12 repurpose second lamp pin
// - Word 7 15 wide lamp, 14 crossover
`timescale 1ns/1ps
`default_nettype none
module isec_top
  import isec_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Host parallel bus, data port split into in/out/enable
  input wire isec_pins_t host_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Strap: high in 8-bit bus mode
  input wire logic bus_width_indicator_i,
  // Event pulses, bit order as the status flags
  input wire logic [5:0] event_i,
  // Serial memory word fetch port
  output logic ee_req_o,
  output logic [2:0] ee_addr_o,
  input wire logic ee_ack_i,
  input wire logic [15:0] ee_word_i,
  input wire logic ee_present_i,
  // Interrupt pin
  output logic irq_o,
  output logic irq_oe_o,
  // Loaded configuration
  output logic ready_o,
  output isec_cfg_t cfg_o,
  output logic [47:0] station_addr_o,
  output logic [15:0] vendor_id_o,
  output logic [15:0] product_id_o,
  output logic pointer_wrap_enable_o,
  output logic [7:0] read_addr_high_o
);

  isec_state_t s_r; // Registered state
  isec_state_t s_nxt; // Next state
  logic cs_act; // Chip select after polarity
  logic rd_act; // Read strobe after polarity
  logic wr_act; // Write strobe after polarity
  logic wr_evt; // Leading edge of a qualified write
  logic pend; // Any enabled flag pending
  logic bus8; // Narrow bus mode

  assign bus8 = bus_width_indicator_i;

  // Strobe polarity follows the loaded pin options
  always_comb begin
    cs_act = s_r.cfg.cs_low ? ~host_i.cs : host_i.cs;
    rd_act = s_r.cfg.rd_low ? ~host_i.rd : host_i.rd;
    wr_act = s_r.cfg.wr_low ? ~host_i.wr : host_i.wr;
    // Acting on the edge keeps a long strobe from clearing twice
    wr_evt = cs_act & wr_act & ~s_r.wr_q & s_r.ready;
  end

  // Next state: loader, register file, interrupt pin
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_q = cs_act & wr_act;
    case (s_r.fsm)
      ISEC_FETCH: begin
        if (!ee_present_i) begin
          // No image: keep defaults and open the bus
          s_nxt.fsm = ISEC_DONE;
          s_nxt.ready = 1'b1;
          s_nxt.ee_req = 1'b0;
        end else begin
          s_nxt.ee_req = 1'b1;
          s_nxt.fsm = ISEC_WAIT;
        end
      end
      ISEC_WAIT: begin
        if (ee_ack_i) begin
          s_nxt.ee_req = 1'b0;
          s_nxt.img[s_r.wcnt] = ee_word_i;
          if (s_r.wcnt == ISEC_W_LAST) begin
            s_nxt.fsm = ISEC_DONE;
            s_nxt.ready = 1'b1;
          end else begin
            s_nxt.wcnt = s_r.wcnt + 3'h1;
            s_nxt.fsm = ISEC_FETCH;
          end
        end
      end
      ISEC_DONE: begin
        s_nxt.ee_req = 1'b0;
      end
      default: begin
        s_nxt.fsm = ISEC_FETCH;
      end
    endcase

    // Apply the image once, on the last word
    if (s_r.fsm == ISEC_WAIT && ee_ack_i && s_r.wcnt == ISEC_W_LAST) begin
      // Byte 0 of the address sits in the low byte of word 0
      s_nxt.mac = {s_nxt.img[2], s_nxt.img[1], s_nxt.img[0]};
      if (s_nxt.img[ISEC_W_CTRL][1:0] == ISEC_ACCEPT) begin
        s_nxt.vid = s_nxt.img[ISEC_W_VID];
        s_nxt.pid = s_nxt.img[ISEC_W_PID];
      end
      if (s_nxt.img[ISEC_W_CTRL][3:2] == ISEC_ACCEPT) begin
        s_nxt.cfg.cs_low = s_nxt.img[ISEC_W_PIN][0];
        s_nxt.cfg.rd_low = s_nxt.img[ISEC_W_PIN][1];
        s_nxt.cfg.wr_low = s_nxt.img[ISEC_W_PIN][2];
        s_nxt.cfg.int_low = s_nxt.img[ISEC_W_PIN][3];
        s_nxt.cfg.int_od = s_nxt.img[ISEC_W_PIN][4];
      end
      // Wake options only matter with the narrow bus
      if (s_nxt.img[ISEC_W_CTRL][7:6] == ISEC_ACCEPT && bus8) begin
        s_nxt.cfg.wake_low = ee_word_i[0];
        s_nxt.cfg.wake_pulse = ee_word_i[1];
        s_nxt.cfg.magic_wake_en = ee_word_i[2];
        s_nxt.cfg.link_wake_en = ee_word_i[3];
      end
      if (s_nxt.img[ISEC_W_CTRL][11:10] == ISEC_ACCEPT) begin
        s_nxt.cfg.led_mode1 = ee_word_i[7];
      end
      if (s_nxt.img[ISEC_W_CTRL][13:12] == ISEC_ACCEPT) begin
        s_nxt.cfg.phy_enable = ee_word_i[8];
      end
      if (s_nxt.img[ISEC_W_CTRL][15:14] == ISEC_ACCEPT) begin
        s_nxt.cfg.auto_crossover = ee_word_i[14];
        // Lamp pin reuse exists only on the wide bus
        if (!bus8) begin
          s_nxt.cfg.second_lamp_pin_sel = ee_word_i[13:12];
          s_nxt.cfg.first_lamp_pin_wide = ee_word_i[15];
        end
      end
    end

    // Index port write, then data port writes
    if (wr_evt && !host_i.cmd) begin
      s_nxt.index = host_i.data;
    end
    // Set wins over clear: an event in the clear cycle stays
    if (wr_evt && host_i.cmd && s_r.index == ISEC_IDX_STATUS) begin
      s_nxt.flags = (s_r.flags & ~host_i.data[5:0]) | event_i;
    end else begin
      s_nxt.flags = s_r.flags | event_i;
    end
    if (wr_evt && host_i.cmd && s_r.index == ISEC_IDX_MASK) begin
      s_nxt.mask = host_i.data & ISEC_MASK_RW;
      if (host_i.data[ISEC_WRAP_BIT]) begin
        s_nxt.rdhi = ISEC_RDHI_WRAP;
      end
    end
    if (wr_evt && host_i.cmd && s_r.index == ISEC_IDX_RDHI) begin
      s_nxt.rdhi = host_i.data;
    end

    // Read data, lagging the strobe by one clock
    s_nxt.doe = cs_act & rd_act & ~wr_act & s_r.ready & host_i.cmd;
    case (s_r.index)
      ISEC_IDX_STATUS: s_nxt.dout = {bus8, 1'b0, s_nxt.flags};
      ISEC_IDX_MASK: s_nxt.dout = s_nxt.mask;
      ISEC_IDX_RDHI: s_nxt.dout = s_nxt.rdhi;
      default: s_nxt.dout = 8'h00;
    endcase

    // Interrupt pin from masked flags
    pend = |(s_nxt.flags & s_nxt.mask[5:0]);
    if (s_nxt.cfg.int_od) begin
      // Open drain: only the asserted level is driven
      s_nxt.irq = ~s_nxt.cfg.int_low;
      s_nxt.irq_oe = pend;
    end else begin
      s_nxt.irq = pend ^ s_nxt.cfg.int_low;
      s_nxt.irq_oe = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.fsm <= ISEC_FETCH;
      s_r.cfg <= ISEC_CFG_DEF;
      s_r.vid <= ISEC_VID_DEF;
      s_r.pid <= ISEC_PID_DEF;
      s_r.irq_oe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign data_o = s_r.dout;
  assign data_oe_o = s_r.doe;
  assign ee_req_o = s_r.ee_req;
  assign ee_addr_o = s_r.wcnt;
  assign irq_o = s_r.irq;
  assign irq_oe_o = s_r.irq_oe;
  assign ready_o = s_r.ready;
  assign cfg_o = s_r.cfg;
  assign station_addr_o = s_r.mac;
  assign vendor_id_o = s_r.vid;
  assign product_id_o = s_r.pid;
  assign pointer_wrap_enable_o = s_r.mask[ISEC_WRAP_BIT];
  assign read_addr_high_o = s_r.rdhi;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  logic [5:0] masked; // Enabled pending flags
  assign masked = s_r.flags & s_r.mask[5:0];

  sequence s_last_ack;
    s_r.fsm == ISEC_WAIT && ee_ack_i && s_r.wcnt == ISEC_W_LAST;
  endsequence

  property p_flag_set;
    |event_i |=> ((s_r.flags & $past(event_i)) == $past(event_i));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set its flag");

  property p_flag_clear;
    wr_evt && host_i.cmd && s_r.index == ISEC_IDX_STATUS && !(|event_i)
      |=> ((s_r.flags & $past(host_i.data[5:0])) == 6'h00);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("write one did not clear flag");

  property p_irq_level;
    !s_r.cfg.int_od |-> irq_o == ((|masked) ^ s_r.cfg.int_low) && irq_oe_o;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin disagrees with masked flags");

  property p_mask_gate;
    (masked == 6'h00) |-> (irq_o == s_r.cfg.int_low) || s_r.cfg.int_od;
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked flag raised interrupt");

  property p_od;
    s_r.cfg.int_od |-> irq_oe_o == (|masked);
  endproperty
  a_od: assert property (p_od)
    else $error("open drain enable wrong");

  property p_wrap;
    wr_evt && host_i.cmd && s_r.index == ISEC_IDX_MASK
      |=> pointer_wrap_enable_o == $past(host_i.data[ISEC_WRAP_BIT])
      && (!pointer_wrap_enable_o || read_addr_high_o == ISEC_RDHI_WRAP);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap enable or read high byte wrong");

  property p_no_early_read;
    !s_r.ready |=> !data_oe_o;
  endproperty
  a_no_early_read: assert property (p_no_early_read)
    else $error("bus answered before image load");

  property p_load_done;
    s_last_ack |=> ready_o ##1 ready_o;
  endproperty
  a_load_done: assert property (p_load_done)
    else $error("loader did not finish");

  property p_pin_reject;
    s_last_ack and s_r.img[ISEC_W_CTRL][3:2] != ISEC_ACCEPT
      |=> cfg_o.cs_low == $past(s_r.cfg.cs_low)
      && cfg_o.int_od == $past(s_r.cfg.int_od);
  endproperty
  a_pin_reject: assert property (p_pin_reject)
    else $error("pin control applied without accept");

  // Request drops for one clock, then returns for the next word
  sequence s_refetch;
    !ee_req_o ##1 (ee_req_o || !ee_present_i);
  endsequence

  // A stuck request would leave the memory model waiting, never answering the next word
  property p_refetch;
    s_r.fsm == ISEC_WAIT && ee_ack_i && s_r.wcnt != ISEC_W_LAST
      |=> s_refetch;
  endproperty
  a_refetch: assert property (p_refetch)
    else $error("loader did not ask for the next word");

  // Word number steps by one on every accepted word but the last
  property p_addr_step;
    s_r.fsm == ISEC_WAIT && ee_ack_i && s_r.wcnt != ISEC_W_LAST
      |=> ee_addr_o == 3'($past(ee_addr_o) + 3'h1);
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("image word number did not step");

  // Host strobes before the image is applied leave registers alone
  property p_early_quiet;
    !s_r.ready |=> $stable(s_r.mask) && $stable(s_r.index)
      && $stable(s_r.rdhi);
  endproperty
  a_early_quiet: assert property (p_early_quiet)
    else $error("register changed before image load");

  // Lamp reuse stays untouched when the narrow bus is strapped
  property p_lamp_narrow;
    s_last_ack ##0 bus8 |=> cfg_o.second_lamp_pin_sel ==
      $past(s_r.cfg.second_lamp_pin_sel)
      && cfg_o.first_lamp_pin_wide == $past(s_r.cfg.first_lamp_pin_wide);
  endproperty
  a_lamp_narrow: assert property (p_lamp_narrow)
    else $error("lamp reuse applied on narrow bus");

  // Wake options stay untouched when the wide bus is strapped
  property p_wake_wide;
    s_last_ack ##0 !bus8 |=> cfg_o.wake_low == $past(s_r.cfg.wake_low)
      && cfg_o.wake_pulse == $past(s_r.cfg.wake_pulse)
      && cfg_o.magic_wake_en == $past(s_r.cfg.magic_wake_en)
      && cfg_o.link_wake_en == $past(s_r.cfg.link_wake_en);
  endproperty
  a_wake_wide: assert property (p_wake_wide)
    else $error("wake options applied on wide bus");

  // Once open, the host bus stays open until the next reset
  property p_ready_hold;
    ready_o |=> ready_o;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without reset");

endmodule : isec_top
`default_nettype wire

// file: inc/isec_pkg.sv
`default_nettype none
package isec_pkg;
  // Register indices behind the data port
  localparam logic [7:0] ISEC_IDX_STATUS = 8'hfe;
  localparam logic [7:0] ISEC_IDX_MASK = 8'hff;
  localparam logic [7:0] ISEC_IDX_RDHI = 8'hf5;
  // Value forced into the read address high byte on wrap enable
  localparam logic [7:0] ISEC_RDHI_WRAP = 8'h0c;
  // Writable mask bits, bit 6 reserved and read as zero
  localparam logic [7:0] ISEC_MASK_RW = 8'hbf;
  localparam int ISEC_WRAP_BIT = 7;
  // Auto-load control field value that accepts a setting
  localparam logic [1:0] ISEC_ACCEPT = 2'b01;
  // Image word numbers
  localparam logic [2:0] ISEC_W_CTRL = 3'h3;
  localparam logic [2:0] ISEC_W_VID = 3'h4;
  localparam logic [2:0] ISEC_W_PID = 3'h5;
  localparam logic [2:0] ISEC_W_PIN = 3'h6;
  localparam logic [2:0] ISEC_W_LAST = 3'h7;
  // Identity defaults; values are arbitrary
  localparam logic [15:0] ISEC_VID_DEF = 16'h1234;
  localparam logic [15:0] ISEC_PID_DEF = 16'h5678;

  // Loader states, one-hot
  typedef enum logic [2:0] {
    ISEC_FETCH = 3'h1,
    ISEC_WAIT = 3'h2,
    ISEC_DONE = 3'h4
  } isec_fsm_t;

  // Host bus pins as sampled, before polarity correction
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic cmd;
    logic [7:0] data;
  } isec_pins_t;

  // Pin and wake options taken from the image
  typedef struct packed {
    logic cs_low;
    logic rd_low;
    logic wr_low;
    logic int_low;
    logic int_od;
    logic wake_low;
    logic wake_pulse;
    logic magic_wake_en;
    logic link_wake_en;
    logic led_mode1;
    logic phy_enable;
    logic [1:0] second_lamp_pin_sel;
    logic first_lamp_pin_wide;
    logic auto_crossover;
  } isec_cfg_t;

  localparam isec_cfg_t ISEC_CFG_DEF = '{cs_low: 1'b1, rd_low: 1'b1,
    wr_low: 1'b1, auto_crossover: 1'b1, default: '0};
  localparam logic [1:0] ISEC_LAMP2_WAIT = 2'b01;
  localparam logic [1:0] ISEC_LAMP2_WAKE = 2'b10;

  // Whole state of the block
  typedef struct packed {
    isec_fsm_t fsm;
    logic [2:0] wcnt;
    logic [7:0][15:0] img;
    logic ready;
    logic ee_req;
    isec_cfg_t cfg;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [47:0] mac;
    logic [5:0] flags;
    logic [7:0] mask;
    logic [7:0] rdhi;
    logic [7:0] index;
    logic wr_q;
    logic [7:0] dout;
    logic doe;
    logic irq;
    logic irq_oe;
  } isec_state_t;
endpackage : isec_pkg
`default_nettype wire

// file: bench/isec_ee_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial memory stand-in: one word per request, after a set delay
module isec_ee_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Image and answer delay
  input wire logic [7:0][15:0] img_i,
  input wire logic [3:0] delay_i,
  // Fetch port, memory side
  input wire logic ee_req_i,
  input wire logic [2:0] ee_addr_i,
  output logic ee_ack_o,
  output logic [15:0] ee_word_o
);
  logic [3:0] cnt_r; // Cycles waited so far
  logic done_r; // Answered, wait for request to drop
  // Word line shows the inverse outside the ack, never a stale word
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ee_ack_o <= 1'b0;
      ee_word_o <= 16'h0000;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else if (ee_ack_o) begin
      ee_ack_o <= 1'b0;
      ee_word_o <= ~ee_word_o;
      done_r <= 1'b1;
    end else if (!ee_req_i) begin
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else if (!done_r && cnt_r >= delay_i) begin
      ee_ack_o <= 1'b1;
      ee_word_o <= img_i[ee_addr_i];
    end else if (!done_r) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : isec_ee_model
`default_nettype wire

// file: bench/test_isec_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_isec_top
  import isec_pkg::*;
;
  localparam isec_pins_t IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  isec_pins_t host = IDLE; // Raw pins, active low strobes
  logic m8 = 1'b0;
  logic pres = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0][15:0] img = '0;
  logic [3:0] dly = 4'h0;
  logic ee_req, ee_ack, doe, irq, irq_oe, ready, wrap, rdoe;
  logic [2:0] ee_addr;
  logic [15:0] ee_word, vid, pid;
  logic [7:0] dout, rdhi, rd, m, c;
  logic [5:0] flags, e;
  logic [47:0] mac;
  isec_cfg_t cfg, ec;
  integer seed = 11103;
  int bad_count = 0;
  int compares = 0;
  always #20 clock_i = ~clock_i;
  isec_top isec_top_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .host_i(host), .data_o(dout), .data_oe_o(doe),
    .bus_width_indicator_i(m8), .event_i(ev), .ee_req_o(ee_req),
    .ee_addr_o(ee_addr), .ee_ack_i(ee_ack), .ee_word_i(ee_word),
    .ee_present_i(pres), .irq_o(irq), .irq_oe_o(irq_oe),
    .ready_o(ready), .cfg_o(cfg), .station_addr_o(mac),
    .vendor_id_o(vid), .product_id_o(pid),
    .pointer_wrap_enable_o(wrap), .read_addr_high_o(rdhi));
  isec_ee_model isec_ee_model_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .img_i(img), .delay_i(dly), .ee_req_i(ee_req), .ee_addr_i(ee_addr),
    .ee_ack_o(ee_ack), .ee_word_o(ee_word));
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic final_report();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Settings the loader should accept, from control word and mode
  function automatic isec_cfg_t exp_cfg(logic [15:0] c3, p, w, logic b8);
    isec_cfg_t r;
    r = ISEC_CFG_DEF;
    if (c3[3:2] == 2'b01) begin
      {r.int_od, r.int_low, r.wr_low, r.rd_low, r.cs_low} = p[4:0];
    end
    if (c3[7:6] == 2'b01 && b8) begin
      {r.link_wake_en, r.magic_wake_en, r.wake_pulse, r.wake_low} = w[3:0];
    end
    r.led_mode1 = (c3[11:10] == 2'b01) ? w[7] : r.led_mode1;
    r.phy_enable = (c3[13:12] == 2'b01) ? w[8] : r.phy_enable;
    if (c3[15:14] == 2'b01) begin
      r.auto_crossover = w[14];
      if (!b8) begin
        {r.first_lamp_pin_wide, r.second_lamp_pin_sel} = {w[15], w[13:12]};
      end
    end
    return r;
  endfunction : exp_cfg
  // Raw pin levels, strobing or idle, under the polarity expected
  function automatic isec_pins_t pins(logic act, is_rd, cmd,
    logic [7:0] d);
    isec_pins_t r;
    r.cs = ec.cs_low ^ act;
    r.rd = ec.rd_low ^ (act & is_rd);
    r.wr = ec.wr_low ^ (act & ~is_rd);
    r.cmd = cmd;
    r.data = d;
    return r;
  endfunction : pins
  // One strobe cycle; release gives the edge detect a gap
  task automatic bus(input logic is_rd, cmd, input logic [7:0] d);
    @(posedge clock_i);
    host <= pins(1'b1, is_rd, cmd, d);
    @(posedge clock_i);
    #1;
    {rdoe, rd} = {doe, dout};
    @(posedge clock_i);
    host <= pins(1'b0, 1'b0, 1'b0, 8'h00);
  endtask : bus
  task automatic wreg(input logic [7:0] idx, val);
    bus(1'b0, 1'b0, idx);
    bus(1'b0, 1'b1, val);
  endtask : wreg
  task automatic rreg(input logic [7:0] idx, exp, input string msg);
    bus(1'b0, 1'b0, idx);
    bus(1'b1, 1'b1, 8'h00);
    chk({rdoe, rd} === {1'b1, exp}, msg);
  endtask : rreg
  // Pin level and enable from pending events and drive options
  task automatic irq_chk();
    logic p;
    #1;
    p = |(flags & m[5:0]);
    chk({irq, irq_oe} === (ec.int_od ? {~ec.int_low, p} :
      {p ^ ec.int_low, 1'b1}), "irq pin");
  endtask : irq_chk
  task automatic run(input logic p_i, b8, input logic [15:0] c3);
    int n;
    for (int i = 0; i < 8; i++) img[i] = 16'($random(seed));
    img[3] = c3;
    ec = p_i ? exp_cfg(c3, img[6], img[7], b8) : ISEC_CFG_DEF;
    flags = 6'h00;
    m = 8'h00;
    @(posedge clock_i);
    host <= IDLE;
    rst_b_i <= 1'b0;
    pres <= p_i;
    m8 <= b8;
    dly <= 4'($random(seed));
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // Corner: host strobes while the image loads are refused
    host <= '{1'b0, 1'b1, 1'b0, 1'b0, ISEC_IDX_MASK};
    @(posedge clock_i);
    host <= '{1'b0, 1'b0, 1'b1, 1'b1, 8'h00};
    repeat (2) @(posedge clock_i);
    #1;
    chk({doe, dout} === {!p_i, 8'h00}, "early access");
    host <= IDLE;
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    // Idle levels now follow the loaded strobe polarity
    @(posedge clock_i);
    host <= pins(1'b0, 1'b0, 1'b0, 8'h00);
    if (n == 300) begin
      chk(1'b0, "ready timeout");
      final_report();
    end
    chk(cfg === ec, "cfg");
    chk(mac === (p_i ? {img[2], img[1], img[0]} : 48'h0), "mac");
    chk({vid, pid} === ((p_i && c3[1:0] == 2'b01) ? {img[4], img[5]} :
      {ISEC_VID_DEF, ISEC_PID_DEF}), "ids");
    for (int k = 0; k < 10; k++) begin
      m = 8'($random(seed));
      wreg(ISEC_IDX_MASK, m);
      rreg(ISEC_IDX_MASK, m & ISEC_MASK_RW, "mask");
      chk(wrap === m[7] && (!m[7] || rdhi === ISEC_RDHI_WRAP), "wrap");
      e = 6'($random(seed));
      @(posedge clock_i);
      ev <= e;
      @(posedge clock_i);
      ev <= 6'h00;
      flags = flags | e;
      irq_chk();
      rreg(ISEC_IDX_STATUS, {b8, 1'b0, flags}, "status");
      c = 8'($random(seed));
      wreg(ISEC_IDX_STATUS, c);
      flags = flags & ~c[5:0];
      irq_chk();
    end
    // Corner: event on the same edge as its clear, set must win
    bus(1'b0, 1'b0, ISEC_IDX_STATUS);
    @(posedge clock_i);
    host <= pins(1'b1, 1'b0, 1'b1, 8'h3f);
    ev <= 6'h01;
    @(posedge clock_i);
    ev <= 6'h00;
    @(posedge clock_i);
    host <= pins(1'b0, 1'b0, 1'b0, 8'h00);
    flags = 6'h01;
    irq_chk();
    rreg(ISEC_IDX_STATUS, {b8, 1'b0, flags}, "set wins");
    $display("test done: image %0b, 8-bit %0b", p_i, b8);
  endtask : run
  initial begin
    run(1'b1, 1'b1, 16'h5555);
    run(1'b1, 1'b0, 16'h5555);
    run(1'b1, 1'b0, 16'haaaa);
    run(1'b0, 1'b0, 16'h5555);
    final_report();
  end
endmodule : test_isec_top
`default_nettype wire
